/* File: verilog/rsc_pkg.sv */
// Purpose: constants and types for the run/stop scan controller
// Assumes: 10 MHz system clock, synchronous active-high reset
// Notes: register offsets are word indices times four
package rsc_pkg;
    // register word offsets (byte addresses)
    localparam logic [7:0] REG_CTRL     = 8'h00;  // run request, variant, cart write
    localparam logic [7:0] REG_STATUS   = 8'h04;  // state, lamps
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;  // sticky events, clear on read
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;  // interrupt enables
    localparam logic [7:0] REG_PROG     = 8'h10;  // logic block program, 16 outputs
    localparam logic [7:0] REG_MODULES  = 8'h14;  // fieldbus slot, modules present
    localparam logic [7:0] REG_INPUTS   = 8'h18;  // sampled digital inputs
    localparam logic [7:0] REG_OUTPUTS  = 8'h1C;  // driven outputs
    localparam logic [7:0] REG_ANALOG   = 8'h20;  // analog select for inputs 1,2,7,8
    // control fields
    localparam int CTRL_RUN     = 0;
    localparam int CTRL_NODISP  = 1;
    localparam int CTRL_CARTWR  = 2;
    localparam int CTRL_FBADDR0 = 3;
    // event bits
    localparam int EV_STATE   = 0;
    localparam int EV_LINK    = 1;
    localparam int EV_CUTOFF  = 2;
    localparam int EV_CARTREJ = 3;
    localparam int EV_W       = 4;
    // sizes
    localparam int N_IN    = 24;
    localparam int N_OUT   = 16;
    localparam int N_BASE_OUT = 4;
    localparam int N_MARK  = 27;
    localparam int N_MOD   = 4;
    // timing
    localparam int CLK_HZ       = 10_000_000;
    localparam int CUTOFF_MS    = 40;   // outputs reset at least this late, at most 100 ms
    localparam int CUTOFF_CYC   = CLK_HZ / 1000 * CUTOFF_MS;
    localparam int SCAN_US      = 100;
    localparam int SCAN_CYC     = CLK_HZ / 1_000_000 * SCAN_US;
    localparam int FLASH_MS     = 250;
    localparam int FLASH_CYC    = CLK_HZ / 1000 * FLASH_MS;
    // lamp colours
    typedef enum logic [1:0] {LAMP_OFF, LAMP_RED, LAMP_GREEN, LAMP_ORANGE} rsc_lamp_t;
    // scan phases
    typedef enum logic [1:0] {PH_STOP, PH_SAMPLE, PH_EVAL, PH_DRIVE} rsc_phase_t;
    // block function
    typedef enum logic [1:0] {FN_AND, FN_OR, FN_XOR, FN_NAND} rsc_fn_t;
    // connector select: 0..23 inputs, 24..27 unused, 28 lo, 29 hi, 30 x, 31 marker
    localparam logic [4:0] SEL_LO = 5'h1C;
    localparam logic [4:0] SEL_HI = 5'h1D;
    localparam logic [4:0] SEL_X  = 5'h1E;
endpackage

/* File: verilog/rsc_blk_if.sv */
// Purpose: carries one logic block's connectors and result
// Assumes: combinational evaluation
// Notes: four connectors per block
`timescale 1ns/1ps
`default_nettype none
interface rsc_blk_if;
    import rsc_pkg::*;
    logic [4:0] sel [4];   // connector select per block input
    logic [N_IN-1:0] in_vec;  // sampled inputs
    rsc_fn_t    fn;        // block function
    logic       y;         // block result
    modport ctl (output sel, output in_vec, output fn, input y);
    modport blk (input sel, input in_vec, input fn, output y);
endinterface
`default_nettype wire

/* File: verilog/rsc_logic_blk.sv */
// Purpose: one four-input basic logic block
// Assumes: connectors chosen by select codes
// Notes: unused inputs take the neutral level of the function
`timescale 1ns/1ps
`default_nettype none
module rsc_logic_blk
    import rsc_pkg::*;
(
    // block connection
    rsc_blk_if.blk b
);
    logic [3:0] v;  // resolved connector levels

    // resolve a connector; neutral is one for and-type, zero for or-type
    function automatic logic resolve(input logic [4:0] s, input logic [N_IN-1:0] iv, input rsc_fn_t f);
        logic r;
        r = 1'b0;
        if (s == SEL_HI) begin
            r = 1'b1;
        end else if (s == SEL_LO) begin
            r = 1'b0;
        end else if (s < 5'(N_IN)) begin
            r = iv[s];
        end else begin
            r = (f == FN_AND || f == FN_NAND);
        end
        return r;
    endfunction

    // four inputs per block
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            v[i] = resolve(b.sel[i], b.in_vec, b.fn);
        end
        unique case (b.fn)
            FN_AND:  b.y = &v;
            FN_OR:   b.y = |v;
            FN_XOR:  b.y = ^v;
            FN_NAND: b.y = ~&v;
        endcase
    end
endmodule
`default_nettype wire

/* File: verilog/rsc_core.sv */
// Purpose: run/stop scan controller with lamps and link cutoff
// Assumes: inputs synchronous to clk_sys; one program block per output
// Notes: outputs follow two cycles after sampling, in the same scan; lost link clears expansion outputs
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rsc_core
    import rsc_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   irq,
    // field pins
    input  wire logic [N_IN-1:0]   digital_input_n,
    input  wire logic [3:0]        fast_input_n,
    input  wire logic              fieldbus_supply_ok,
    input  wire logic [N_MOD-1:0]  module_present,
    input  wire logic [N_MOD-1:0]  module_link_ok,
    input  wire logic [N_MOD-1:0]  module_init_done,
    output logic      [N_OUT-1:0]  digital_output_n,
    output logic      [3:0]        fast_count_pulse,
    // lamps
    output rsc_lamp_t              base_lamp,
    output rsc_lamp_t              module_lamp [N_MOD],
    output rsc_lamp_t              fieldbus_lamp
);
    // control registers
    logic [3:0]          ctrl_q;         // run, no-display, cart write, address zero
    logic [EV_W-1:0]     ev_stat_q;      // sticky events
    logic [EV_W-1:0]     ev_mask_q;      // interrupt enables
    logic [1:0]          fn_q [N_OUT];   // block function per output
    logic [4:0]          sel_q [N_OUT][4];
    logic [1:0]          fb_pos_q;       // fieldbus module slot
    logic [3:0]          analog_sel_q;   // inputs 1,2,7,8 read as analog
    // scan state
    rsc_phase_t          phase_q;
    logic [15:0]         scan_cnt_q;     // phase timer
    logic [N_IN-1:0]     img_in_q;       // input image
    logic [N_OUT-1:0]    img_out_q;      // computed output image
    logic [N_OUT-1:0]    y_vec;          // block results
    logic                link_ok;        // all modules communicating
    logic                link_ok_q;
    logic [22:0]         cut_cnt_q;      // cutoff timer
    logic                cut_q;          // expansion outputs forced off
    logic [23:0]         flash_cnt_q;
    logic                flash_q;
    logic [3:0]          fast_prev_q;
    logic [N_MOD-1:0]    mod_reach;      // modules reachable from base

    // one logic block per output
    genvar g;
    generate
        for (g = 0; g < N_OUT; g++) begin : g_blk
            rsc_blk_if bi ();
            assign bi.sel[0] = sel_q[g][0];
            assign bi.sel[1] = sel_q[g][1];
            assign bi.sel[2] = sel_q[g][2];
            assign bi.sel[3] = sel_q[g][3];
            assign bi.in_vec = img_in_q;
            assign bi.fn     = rsc_fn_t'(fn_q[g]);
            assign y_vec[g]  = bi.y;
            rsc_logic_blk u_blk (.b(bi));
        end
    endgenerate

    // modules right of the fieldbus slot lose link without its supply
    always_comb begin
        for (int m = 0; m < N_MOD; m++) begin
            mod_reach[m] = module_link_ok[m] && (fieldbus_supply_ok || m <= int'(fb_pos_q));
        end
        link_ok = &(mod_reach | ~module_present);
    end

    // scan sequencer: stop, or sample/evaluate/drive looping
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phase_q    <= PH_STOP;
            scan_cnt_q <= 16'h0000;
        end else if (!ctrl_q[CTRL_RUN]) begin
            phase_q    <= PH_STOP;
            scan_cnt_q <= 16'h0000;
        end else begin
            unique case (phase_q)
                PH_STOP:   phase_q <= PH_SAMPLE;
                PH_SAMPLE: phase_q <= PH_EVAL;
                PH_EVAL:   phase_q <= PH_DRIVE;
                PH_DRIVE: begin
                    // wait out the scan period, then loop
                    if (scan_cnt_q >= 16'(SCAN_CYC - 3)) begin
                        scan_cnt_q <= 16'h0000;
                        phase_q    <= PH_SAMPLE;
                    end else begin
                        scan_cnt_q <= scan_cnt_q + 16'h0001;
                    end
                end
            endcase
        end
    end

    // input image: captured only in sample phase; analog-selected inputs read zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            img_in_q <= '0;
        end else if (phase_q == PH_SAMPLE) begin
            img_in_q <= digital_input_n;
            // analog use of inputs 1,2,7,8 masks their digital read
            if (analog_sel_q[0]) img_in_q[0] <= 1'b0;
            if (analog_sel_q[1]) img_in_q[1] <= 1'b0;
            if (analog_sel_q[2]) img_in_q[6] <= 1'b0;
            if (analog_sel_q[3]) img_in_q[7] <= 1'b0;
        end
    end

    // program evaluation; image held frozen in stop
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            img_out_q <= '0;
        end else if (phase_q == PH_EVAL) begin
            img_out_q <= y_vec;
        end
    end

    // fast inputs 3..6: edge pulses besides normal digital use
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fast_prev_q      <= 4'h0;
            fast_count_pulse <= 4'h0;
        end else begin
            fast_prev_q      <= fast_input_n;
            fast_count_pulse <= (phase_q == PH_STOP) ? 4'h0 : (fast_input_n & ~fast_prev_q);
        end
    end

    // link loss timer: expansion outputs reset 40 ms after interruption
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            link_ok_q <= 1'b1;
            cut_cnt_q <= '0;
            cut_q     <= 1'b0;
        end else begin
            link_ok_q <= link_ok;
            if (link_ok) begin
                cut_cnt_q <= '0;
                cut_q     <= 1'b0;
            end else if (cut_cnt_q >= 23'(CUTOFF_CYC - 1)) begin
                cut_q <= 1'b1;
            end else begin
                cut_cnt_q <= cut_cnt_q + 23'h000001;
            end
        end
    end

    // output drive: off in stop, base outputs kept if only modules fail
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            digital_output_n <= '0;
        end else if (phase_q == PH_STOP) begin
            digital_output_n <= '0;
        end else if (phase_q == PH_DRIVE && scan_cnt_q == 16'h0000) begin
            digital_output_n <= img_out_q;
            // expansion outputs numbered after base outputs, in slot order
            if (cut_q) digital_output_n[N_OUT-1:N_BASE_OUT] <= '0;
        end else if (cut_q) begin
            digital_output_n[N_OUT-1:N_BASE_OUT] <= '0;
        end
    end

    // flash timer for zero-address indication
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flash_cnt_q <= '0;
            flash_q     <= 1'b0;
        end else if (flash_cnt_q >= 24'(FLASH_CYC - 1)) begin
            flash_cnt_q <= '0;
            flash_q     <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 24'h000001;
        end
    end

    // lamps
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            base_lamp     <= LAMP_RED;
            fieldbus_lamp <= LAMP_RED;
            for (int m = 0; m < N_MOD; m++) module_lamp[m] <= LAMP_OFF;
        end else begin
            base_lamp <= ctrl_q[CTRL_NODISP] ? ((phase_q == PH_STOP) ? LAMP_RED : LAMP_GREEN) : LAMP_OFF;
            for (int m = 0; m < N_MOD; m++) begin
                if (!module_present[m])       module_lamp[m] <= LAMP_OFF;
                else if (!module_init_done[m]) module_lamp[m] <= LAMP_ORANGE;
                else if (!mod_reach[m])        module_lamp[m] <= LAMP_RED;
                else                           module_lamp[m] <= LAMP_GREEN;
            end
            if (ctrl_q[CTRL_FBADDR0])    fieldbus_lamp <= flash_q ? LAMP_RED : LAMP_ORANGE;
            else if (fieldbus_supply_ok) fieldbus_lamp <= LAMP_GREEN;
            else                         fieldbus_lamp <= LAMP_RED;
        end
    end

    // register writes; cartridge write refused without display
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q       <= 4'h0;
            fb_pos_q     <= 2'h0;
            analog_sel_q <= 4'h0;
            ev_mask_q    <= '0;
            for (int o = 0; o < N_OUT; o++) begin
                fn_q[o] <= 2'h0;
                for (int k = 0; k < 4; k++) sel_q[o][k] <= SEL_X;
            end
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL: begin
                    ctrl_q <= reg_wdata[3:0];
                    if (reg_wdata[CTRL_NODISP]) ctrl_q[CTRL_CARTWR] <= 1'b0;
                end
                REG_IRQ_MASK: ev_mask_q <= reg_wdata[EV_W-1:0];
                REG_PROG: begin
                    // [27:24] output, [23:22] fn, [19:0] four selects
                    fn_q[reg_wdata[27:24]] <= reg_wdata[23:22];
                    for (int k = 0; k < 4; k++) sel_q[reg_wdata[27:24]][k] <= reg_wdata[5*k +: 5];
                end
                REG_MODULES: fb_pos_q     <= reg_wdata[1:0];
                REG_ANALOG:  analog_sel_q <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    logic [EV_W-1:0]     ev_set;         // events raised this cycle

    // event sources, one bit each
    always_comb begin
        ev_set              = '0;
        ev_set[EV_STATE]    = (phase_q == PH_STOP) != !ctrl_q[CTRL_RUN];
        ev_set[EV_LINK]     = link_ok_q != link_ok;
        ev_set[EV_CUTOFF]   = !link_ok && cut_cnt_q == 23'(CUTOFF_CYC - 1);
        ev_set[EV_CARTREJ]  = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_NODISP] && reg_wdata[CTRL_CARTWR];
    end

    // sticky events, read clears; set wins over clear so no event is lost
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ev_stat_q <= '0;
        end else if (reg_rd && reg_addr == REG_IRQ_STAT) begin
            ev_stat_q <= ev_set;
        end else begin
            ev_stat_q <= ev_stat_q | ev_set;
        end
    end

    // read data one cycle later, zero on unmapped
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
            irq       <= 1'b0;
        end else begin
            irq       <= |(ev_stat_q & ev_mask_q);
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_CTRL:     reg_rdata <= {28'h0, ctrl_q};
                    REG_STATUS:   reg_rdata <= {24'h0, fieldbus_lamp, base_lamp, cut_q, link_ok_q, phase_q};
                    REG_IRQ_STAT: reg_rdata <= {28'h0, ev_stat_q};
                    REG_IRQ_MASK: reg_rdata <= {28'h0, ev_mask_q};
                    REG_MODULES:  reg_rdata <= {24'h0, module_present, 2'h0, fb_pos_q};
                    REG_INPUTS:   reg_rdata <= {8'h0, img_in_q};
                    REG_OUTPUTS:  reg_rdata <= {16'h0, digital_output_n};
                    REG_ANALOG:   reg_rdata <= {28'h0, analog_sel_q};
                    default:      reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // stop keeps outputs off
    property p_stop_off;
        @(posedge clk_sys) disable iff (sys_rst)
        (phase_q == PH_STOP) |=> (digital_output_n == '0);
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("outputs on in stop");

    // stop does not sample
    property p_stop_nosample;
        @(posedge clk_sys) disable iff (sys_rst)
        (phase_q == PH_STOP) |=> $stable(img_in_q);
    endproperty
    a_stop_nosample: assert property (p_stop_nosample) else $error("input sampled in stop");

    // run steps from sample to eval
    property p_run_seq;
        @(posedge clk_sys) disable iff (sys_rst)
        (phase_q == PH_SAMPLE && ctrl_q[CTRL_RUN]) |=> (phase_q == PH_EVAL);
    endproperty
    a_run_seq: assert property (p_run_seq) else $error("sample not followed by eval");

    // scan repeats; a full pass is one scan period long
    localparam int SCAN_MAX = SCAN_CYC;  // longest gap between two samples
    property p_loop;
        @(posedge clk_sys) disable iff (sys_rst)
        (phase_q == PH_SAMPLE) |-> ##[1:SCAN_MAX] (phase_q == PH_SAMPLE || phase_q == PH_STOP);
    endproperty
    a_loop: assert property (p_loop) else $error("scan did not repeat");

    // no-display lamp green in run
    property p_lamp;
        @(posedge clk_sys) disable iff (sys_rst)
        (ctrl_q[CTRL_NODISP] && phase_q == PH_DRIVE) |=> (base_lamp == LAMP_GREEN);
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp not green in run");

    // cutoff never before the least time
    property p_cut;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(cut_q) |-> (cut_cnt_q == 23'(CUTOFF_CYC - 1));
    endproperty
    a_cut: assert property (p_cut) else $error("cutoff timing wrong");

    // no cartridge write without display
    property p_cart;
        @(posedge clk_sys) disable iff (sys_rst)
        ctrl_q[CTRL_NODISP] |-> !ctrl_q[CTRL_CARTWR];
    endproperty
    a_cart: assert property (p_cart) else $error("cartridge write allowed");

    // zero address flashes
    property p_flash;
        @(posedge clk_sys) disable iff (sys_rst)
        ctrl_q[CTRL_FBADDR0] ##1 ctrl_q[CTRL_FBADDR0] |-> (fieldbus_lamp == LAMP_RED || fieldbus_lamp == LAMP_ORANGE);
    endproperty
    a_flash: assert property (p_flash) else $error("zero address not flashing");

    // cutoff keeps expansion outputs off
    property p_cut_off;
        @(posedge clk_sys) disable iff (sys_rst)
        cut_q |=> (digital_output_n[N_OUT-1:N_BASE_OUT] == '0);
    endproperty
    a_cut_off: assert property (p_cut_off) else $error("expansion outputs on after cutoff");

    // stop reads no fast inputs either
    property p_stop_nopulse;
        @(posedge clk_sys) disable iff (sys_rst)
        (phase_q == PH_STOP) |=> (fast_count_pulse == 4'h0);
    endproperty
    a_stop_nopulse: assert property (p_stop_nopulse) else $error("fast pulse in stop");
endmodule
`default_nettype wire

/* File: testbench/rsc_field_model.sv */
// Purpose: field side stand-in: switches, loads and expansion slots
// Assumes: bench sets switch levels and slot states; model registers them
// Notes: fast inputs mirror inputs 3 to 6; loads only follow the outputs
`timescale 1ns/1ps
`default_nettype none
module rsc_field_model
    import rsc_pkg::*;
(
    // clock
    input  wire logic             clk_sys,
    // bench control
    input  wire logic [N_IN-1:0]  sw_level,
    input  wire logic             supply_on,
    input  wire logic [N_MOD-1:0] slot_link,
    input  wire logic [N_MOD-1:0] slot_ready,
    // pins toward the device
    output logic      [N_IN-1:0]  digital_input_n,
    output logic      [3:0]       fast_input_n,
    output logic                  fieldbus_supply_ok,
    output logic      [N_MOD-1:0] module_present,
    output logic      [N_MOD-1:0] module_link_ok,
    output logic      [N_MOD-1:0] module_init_done,
    // loads
    input  wire logic [N_OUT-1:0] digital_output_n,
    output logic      [N_OUT-1:0] load_on
);
    // switches settle one cycle after the bench moves them, like a real contact
    always_ff @(posedge clk_sys) begin
        digital_input_n    <= sw_level;
        fast_input_n       <= sw_level[5:2];
        fieldbus_supply_ok <= supply_on;
        module_present     <= {N_MOD{1'b1}};
        module_link_ok     <= slot_link;
        module_init_done   <= slot_ready;
    end
    // loads just follow the driven outputs
    assign load_on = digital_output_n;
endmodule
`default_nettype wire

/* File: testbench/rsc_core_tb.sv */
// Purpose: self-checking bench for the run/stop scan controller
// Assumes: 10 MHz clock, reset held five cycles
// Notes: link cutoff timing is too long for this run and is not timed here
`timescale 1ns/1ps
`default_nettype none
module rsc_core_tb;
    import rsc_pkg::*;
    logic clk_sys = 1'b0;  // system clock
    logic sys_rst = 1'b1;  // sync reset
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, irq;
    logic [N_IN-1:0] sw_level = '0, digital_input_n;
    logic supply_on = 1'b1, fieldbus_supply_ok;
    logic [N_MOD-1:0] slot_link = 4'hD, slot_ready = 4'hB;  // slot1 unlinked, slot2 initializing
    logic [N_MOD-1:0] module_present, module_link_ok, module_init_done;
    logic [3:0] fast_input_n, fast_count_pulse;
    logic [N_OUT-1:0] digital_output_n, load_on;
    rsc_lamp_t base_lamp, fieldbus_lamp, module_lamp [N_MOD];
    int failures = 0, total_checks = 0, cyc = 0;
    logic [31:0] rd;
    logic [3:0] fast_seen = 4'h0;  // fast pulses seen so far
    logic [23:0] tbl [3] = '{24'h000013, 24'h00000C, 24'h000010};
    always #50 clk_sys = ~clk_sys;
    // collect fast pulses; skipped in reset, where the outputs are still unknown
    always @(posedge clk_sys) begin
        if (!sys_rst) fast_seen <= fast_seen | fast_count_pulse;
    end
    rsc_field_model i_rsc_field_model (.clk_sys(clk_sys), .sw_level(sw_level), .supply_on(supply_on),
        .slot_link(slot_link), .slot_ready(slot_ready), .digital_input_n(digital_input_n),
        .fast_input_n(fast_input_n), .fieldbus_supply_ok(fieldbus_supply_ok),
        .module_present(module_present), .module_link_ok(module_link_ok),
        .module_init_done(module_init_done), .digital_output_n(digital_output_n), .load_on(load_on));
    rsc_core i_rsc_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .digital_input_n(digital_input_n), .fast_input_n(fast_input_n),
        .fieldbus_supply_ok(fieldbus_supply_ok), .module_present(module_present),
        .module_link_ok(module_link_ok), .module_init_done(module_init_done),
        .digital_output_n(digital_output_n), .fast_count_pulse(fast_count_pulse),
        .base_lamp(base_lamp), .module_lamp(module_lamp), .fieldbus_lamp(fieldbus_lamp));
    // verdict and end of run, also reached by the timeout
    task automatic end_sim();
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // value compare; x never matches
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // one-cycle read strobe; data stand only in the following cycle
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // two full scans guarantee a sample and a drive have both passed
    task automatic scans();
        repeat (2 * SCAN_CYC + 20) @(posedge clk_sys);
        #1;
    endtask
    // outputs of the four programmed blocks for a switch pattern
    function automatic logic [3:0] exp_out(input logic [23:0] s);
        return {~s[4], s[2] ^ s[3], s[1], s[0]};
    endfunction
    // hang guard: the run takes about fourteen scans, under half this limit
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 30000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk("base_lamp", LAMP_RED, 32'(base_lamp));
        chk("fieldbus_lamp", LAMP_RED, 32'(fieldbus_lamp));
        chk("outputs", 32'h0, 32'(digital_output_n));
        chk("irq", 32'h0, 32'(irq));
        // or with lo, and with hi, xor of two, nand with hi; spare connectors unused
        wr(REG_PROG, {8'h00, FN_OR, 2'h0, SEL_X, SEL_X, SEL_LO, 5'd0});
        wr(REG_PROG, {8'h01, FN_AND, 2'h0, SEL_X, SEL_X, SEL_HI, 5'd1});
        wr(REG_PROG, {8'h02, FN_XOR, 2'h0, SEL_X, SEL_X, 5'd3, 5'd2});
        wr(REG_PROG, {8'h03, FN_NAND, 2'h0, SEL_X, 5'h1B, SEL_HI, 5'd4});
        wr(REG_IRQ_MASK, 32'h1);
        sw_level <= 24'h000005;
        scans();
        chk("stop outputs", 32'h0, 32'(digital_output_n));
        rdr(REG_INPUTS, rd);
        chk("stop inputs", 32'h0, rd);
        // run with no display and a cartridge write request
        wr(REG_CTRL, 32'h7);
        scans();
        chk("irq", 32'h1, 32'(irq));
        rdr(REG_CTRL, rd);
        chk("ctrl", 32'h3, rd);
        rdr(REG_IRQ_STAT, rd);
        chk("events", 32'h9, rd & 32'h9);
        rdr(8'hFC, rd);
        chk("unmapped", 32'h0, rd);
        chk("irq cleared", 32'h0, 32'(irq));
        chk("base_lamp", LAMP_GREEN, 32'(base_lamp));
        chk("fieldbus_lamp", LAMP_GREEN, 32'(fieldbus_lamp));
        chk("slot0", LAMP_GREEN, 32'(module_lamp[0]));
        chk("slot1", LAMP_RED, 32'(module_lamp[1]));
        chk("slot2", LAMP_ORANGE, 32'(module_lamp[2]));
        chk("outputs", 32'(exp_out(24'h000005)), 32'(digital_output_n[3:0]));
        rdr(REG_INPUTS, rd);
        chk("inputs", 32'h5, rd);
        // each new pattern must show at the loads on a following scan
        for (int i = 0; i < 3; i++) begin
            sw_level <= tbl[i];
            scans();
            chk("outputs", 32'(exp_out(tbl[i])), 32'(load_on[3:0]));
        end
        // rises of inputs 3..6 in run only; the one made in stop is not seen
        chk("fast pulses", 32'h7, 32'(fast_seen));
        supply_on <= 1'b0;
        wr(REG_ANALOG, 32'hF);
        sw_level <= 24'hFFFFFF;
        scans();
        chk("fieldbus_lamp", LAMP_RED, 32'(fieldbus_lamp));
        chk("slot3", LAMP_RED, 32'(module_lamp[3]));
        chk("slot0", LAMP_GREEN, 32'(module_lamp[0]));
        rdr(REG_INPUTS, rd);
        chk("analog inputs", 32'h00FFFF3C, rd);
        wr(REG_CTRL, 32'h2);
        scans();
        chk("stop outputs", 32'h0, 32'(digital_output_n));
        chk("base_lamp", LAMP_RED, 32'(base_lamp));
        // link lost well under 40 ms: no cutoff yet
        rdr(REG_STATUS, rd);
        chk("status", 32'h50, rd);
        wr(REG_CTRL, 32'hA);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("fieldbus_lamp", LAMP_ORANGE, 32'(fieldbus_lamp));
        end_sim();
    end
endmodule
`default_nettype wire
